//--- verilog/advm_regs.svh
// register offsets, field positions, reset values, gain limits and rate codes for the volume stage
//------------------------------------------------------------------------------
// What this block does
// - left mute at D7, resets set, muted
// - left fine gain D6-D4, 0 to -0.4 dB
// - right mute at D3, resets set, muted
// - right fine gain D2-D0, same code table
// - left coarse D6-D0, signed half-dB steps
// - low negative coarse codes clamp to -12 dB
// - right coarse uses same half-dB encoding
// - both coarse fields reset to zero dB
// - coarse D7 reserved, reads zero, ignored
// - coarse volume soft-steps per selected sample rate
//------------------------------------------------------------------------------
`ifndef ADVM_REGS_SVH
`define ADVM_REGS_SVH

`define ADVM_OFS_FINE        8'h52
`define ADVM_OFS_LEFT_VOL    8'h53
`define ADVM_OFS_RIGHT_VOL   8'h54

`define ADVM_RST_FINE        8'h88
`define ADVM_RST_VOL         8'h00

`define ADVM_BIT_LEFT_MUTE   7
`define ADVM_BIT_RIGHT_MUTE  3
`define ADVM_FLD_LEFT_FINE   6:4
`define ADVM_FLD_RIGHT_FINE  2:0
`define ADVM_FLD_VOL         6:0

// coarse limits in half-dB steps
`define ADVM_VOL_MIN         8'shE8
`define ADVM_VOL_MAX         8'sh28

// soft-step rate codes
`define ADVM_STEP_EACH       2'h0
`define ADVM_STEP_EVERY2     2'h1

// unity gain in the Q1.15 multiplier format
`define ADVM_UNITY           16'h8000
// one octave of gain in half-dB steps
`define ADVM_OCTAVE_STEPS    7'h0C

`endif

//--- verilog/advm_pkg.sv
// types shared by the digital volume and mute stage
package advm_pkg;

	// per-channel control as held in the register file
	typedef struct packed {
		logic       mute;
		logic [2:0] fine;
		logic [6:0] coarse;
	} advm_chan_cfg_s;

	// soft-step rate selection
	typedef enum logic [1:0] {
		ADVM_RATE_EACH   = 2'b00,
		ADVM_RATE_EVERY2 = 2'b01,
		ADVM_RATE_NOW    = 2'b10,
		ADVM_RATE_RSVD   = 2'b11
	} advm_rate_e;

endpackage : advm_pkg

//--- verilog/advm_volume.sv
// digital fine/coarse volume, soft stepping and mute for a stereo sample path
`timescale 1ns/1ps
`include "advm_regs.svh"

module advm_volume #(
	parameter int SMP_W = 16
) (
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rstn,
	// register port
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	input  wire logic [7:0]             i_reg_addr,
	input  wire logic [7:0]             i_reg_wdata,
	output logic      [7:0]             o_reg_rdata,
	output logic                        o_reg_rvalid,
	// soft-step rate from the neighbouring digital control register
	input  wire advm_pkg::advm_rate_e   i_step_rate,
	// sample path
	input  wire logic                   i_smp_valid,
	input  wire logic signed [SMP_W-1:0] i_smp_left,
	input  wire logic signed [SMP_W-1:0] i_smp_right,
	output logic                        o_smp_valid,
	output logic signed [SMP_W-1:0]     o_smp_left,
	output logic signed [SMP_W-1:0]     o_smp_right,
	output logic                        o_vol_settled
);
	import advm_pkg::*;

	localparam int XW = SMP_W + 24;

	// the gain path works at XW bits: the sample is scaled by whole octaves,
	// then by the half-dB mantissa and the fine factor, each in Q1.15, and
	// only the last step drops back to SMP_W, with saturation

	// sample limits kept at the wide width so the clamp compares signed values
	localparam logic signed [XW-1:0] SAT_HI = XW'({(SMP_W-1){1'b1}});
	localparam logic signed [XW-1:0] SAT_LO = ~SAT_HI;

	//--------------------------------------------------------------------------
	// lookup functions
	//--------------------------------------------------------------------------

	// gain of one half-dB step inside an octave, Q1.15 unsigned
	// twelve half-dB steps are taken as one octave, trading a small error for a shift
	function automatic logic [15:0] step_mant(input logic [3:0] r);
		case (r)
			4'h0:    step_mant = 16'h8000;
			4'h1:    step_mant = 16'h8795;
			4'h2:    step_mant = 16'h8F9E;
			4'h3:    step_mant = 16'h9821;
			4'h4:    step_mant = 16'hA125;
			4'h5:    step_mant = 16'hAAB1;
			4'h6:    step_mant = 16'hB4CE;
			4'h7:    step_mant = 16'hBF85;
			4'h8:    step_mant = 16'hCADE;
			4'h9:    step_mant = 16'hD6E3;
			4'hA:    step_mant = 16'hE39E;
			4'hB:    step_mant = 16'hF11B;
			default: step_mant = `ADVM_UNITY;
		endcase
	endfunction : step_mant

	// fine attenuation in 0.1 dB steps, reserved codes fall back to unity
	// the host must not use the reserved codes; unity keeps a stray write harmless
	function automatic logic [15:0] fine_mant(input logic [2:0] code);
		case (code)
			3'h0:    fine_mant = `ADVM_UNITY;
			3'h1:    fine_mant = 16'h7E89; // -0.1 dB
			3'h2:    fine_mant = 16'h7D16; // -0.2 dB
			3'h3:    fine_mant = 16'h7BA8; // -0.3 dB
			3'h4:    fine_mant = 16'h7A3D; // -0.4 dB
			default: fine_mant = `ADVM_UNITY;
		endcase
	endfunction : fine_mant

	// coarse code to half-dB steps, the far negative codes saturate
	// reserved codes above +20 dB also clamp, which keeps the octave shift in range
	function automatic logic signed [7:0] coarse_steps(input logic [6:0] code);
		logic signed [7:0] v;
		v = {code[6], code};
		if (v < `ADVM_VOL_MIN)
			coarse_steps = `ADVM_VOL_MIN;
		else if (v > `ADVM_VOL_MAX)
			coarse_steps = `ADVM_VOL_MAX;
		else
			coarse_steps = v;
	endfunction : coarse_steps

	// clamp a wide product to the sample range instead of letting it wrap
	function automatic logic signed [SMP_W-1:0] sat_smp(input logic signed [XW-1:0] v);
		if (v > SAT_HI)
			sat_smp = SAT_HI[SMP_W-1:0];
		else if (v < SAT_LO)
			sat_smp = SAT_LO[SMP_W-1:0];
		else
			sat_smp = v[SMP_W-1:0];
	endfunction : sat_smp

	//--------------------------------------------------------------------------
	// register file
	//--------------------------------------------------------------------------

	// stored fields; bit 7 of the coarse registers has no flop at all
	logic [7:0] fine_reg;
	logic [6:0] left_vol;
	logic [6:0] right_vol;

	// host writes; mute bits come out of reset set
	// a write lands at the edge that takes it; unmapped offsets are ignored
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			fine_reg  <= `ADVM_RST_FINE;
			left_vol  <= 7'(`ADVM_RST_VOL);
			right_vol <= 7'(`ADVM_RST_VOL);
		end
		else if (i_reg_wr)
		begin
			case (i_reg_addr)
				`ADVM_OFS_FINE:      fine_reg  <= i_reg_wdata;
				`ADVM_OFS_LEFT_VOL:  left_vol  <= i_reg_wdata[`ADVM_FLD_VOL];
				`ADVM_OFS_RIGHT_VOL: right_vol <= i_reg_wdata[`ADVM_FLD_VOL];
				default:             ;
			endcase
		end
	end

	// registered read, reserved bit and unmapped offsets read zero
	// read data stands until the next read strobe replaces it
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd)
			begin
				case (i_reg_addr)
					`ADVM_OFS_FINE:      o_reg_rdata <= fine_reg;
					`ADVM_OFS_LEFT_VOL:  o_reg_rdata <= {1'b0, left_vol};
					`ADVM_OFS_RIGHT_VOL: o_reg_rdata <= {1'b0, right_vol};
					default:             o_reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// index 0 is the left channel, index 1 the right
	advm_chan_cfg_s cfg [2];

	// split the registers into per-channel control
	// mute and fine gain reach the path at once; only the coarse level steps
	always_comb
	begin
		cfg[0].mute   = fine_reg[`ADVM_BIT_LEFT_MUTE];
		cfg[0].fine   = fine_reg[`ADVM_FLD_LEFT_FINE];
		cfg[0].coarse = left_vol;
		cfg[1].mute   = fine_reg[`ADVM_BIT_RIGHT_MUTE];
		cfg[1].fine   = fine_reg[`ADVM_FLD_RIGHT_FINE];
		cfg[1].coarse = right_vol;
	end

	//--------------------------------------------------------------------------
	// soft-step pacing
	//--------------------------------------------------------------------------

	logic half_phase;
	logic step_en;

	// every-other-sample phase for the slow rate
	// the phase runs on every strobe whatever the rate, so the first slow
	// step lands on the first or the second strobe after a rate change
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			half_phase <= 1'b0;
		else if (i_smp_valid)
			half_phase <= ~half_phase;
	end

	// one step per sample, per two samples, or jump at once
	// immediate codes never raise the enable; the walk jumps straight away
	always_comb
	begin
		case (i_step_rate)
			ADVM_RATE_EACH:   step_en = i_smp_valid;
			ADVM_RATE_EVERY2: step_en = i_smp_valid & half_phase;
			default:          step_en = 1'b0;
		endcase
	end

	//--------------------------------------------------------------------------
	// per-channel gain
	//--------------------------------------------------------------------------

	// per-channel views of the sample path, index 0 left
	logic signed [SMP_W-1:0] in_smp  [2];
	logic signed [SMP_W-1:0] out_smp [2];
	logic                    settled [2];

	assign in_smp[0] = i_smp_left;
	assign in_smp[1] = i_smp_right;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			logic signed [7:0]   cur_steps;
			logic signed [7:0]   tgt_steps;
			logic signed [7:0]   next_steps;
			logic [6:0]          idx;
			logic [2:0]          octave;
			logic [3:0]          frac;
			logic signed [XW-1:0] p_coarse;
			logic signed [XW-1:0] p_fine;
			logic signed [XW-1:0] p_shift;
			logic signed [XW-1:0] p_out;
			logic signed [SMP_W-1:0] next_out;

			assign tgt_steps = coarse_steps(cfg[ch].coarse);

			// walk the applied level one half-dB step toward the target
			// a reserved rate code is treated as an immediate change
			always_comb
			begin
				next_steps = cur_steps;
				if (i_step_rate == ADVM_RATE_NOW || i_step_rate == ADVM_RATE_RSVD)
					next_steps = tgt_steps;
				else if (step_en && cur_steps < tgt_steps)
					next_steps = cur_steps + 8'sh01;
				else if (step_en && cur_steps > tgt_steps)
					next_steps = cur_steps - 8'sh01;
			end

			// applied level, starts at 0 dB like the coarse registers
			always_ff @(posedge i_ref_clk or negedge i_rstn)
			begin
				if (!i_rstn)
					cur_steps <= 8'sh00;
				else
					cur_steps <= next_steps;
			end

			// split the level into whole octaves and half-dB steps within one
			// counted from -12 dB, so the index is never negative
			always_comb
			begin
				idx    = 7'(cur_steps - `ADVM_VOL_MIN);
				octave = 3'(idx / `ADVM_OCTAVE_STEPS);
				frac   = 4'(idx % `ADVM_OCTAVE_STEPS);
			end

			// coarse and fine gains multiply, so their dB values add; the octave
			// shift comes first so that no later truncation gets magnified by it
			always_comb
			begin
				p_shift  = XW'(in_smp[ch]) <<< octave;
				p_coarse = (p_shift * $signed({1'b0, step_mant(frac)})) >>> 15;
				p_fine   = (p_coarse * $signed({1'b0, fine_mant(cfg[ch].fine)})) >>> 15;
				p_out    = p_fine >>> 2; // -12 dB sits two octaves below unity
				next_out = sat_smp(p_out);
			end

			// mute acts on the very next strobe and is not soft-stepped;
			// between strobes the last sample stands
			always_ff @(posedge i_ref_clk or negedge i_rstn)
			begin
				if (!i_rstn)
					out_smp[ch] <= '0;
				else if (i_smp_valid)
					out_smp[ch] <= cfg[ch].mute ? '0 : next_out;
			end

			// low from the cycle after a new target is written until it is reached
			assign settled[ch] = (cur_steps == tgt_steps);
		end
	endgenerate

	//--------------------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------------------

	// one-cycle latency from sample in to sample out
	// the valid pulse follows the strobe even for a muted channel
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_smp_valid <= 1'b0;
		else
			o_smp_valid <= i_smp_valid;
	end

	assign o_smp_left    = out_smp[0];
	assign o_smp_right   = out_smp[1];
	assign o_vol_settled = settled[0] & settled[1];

endmodule : advm_volume

//--- verification/advm_volume_asserts.sv
// port assertions for the volume and mute stage
`timescale 1ns/1ps
module advm_volume_asserts #(
	parameter int SMP_W = 16
) (
	input wire logic			i_ref_clk,
	input wire logic			i_rstn,
	input wire logic			i_reg_wr,
	input wire logic			i_reg_rd,
	input wire logic [7:0]			i_reg_addr,
	input wire logic [7:0]			i_reg_wdata,
	input wire logic [7:0]			o_reg_rdata,
	input wire logic			o_reg_rvalid,
	input wire advm_pkg::advm_rate_e	i_step_rate,
	input wire logic			i_smp_valid,
	input wire logic			o_smp_valid,
	input wire logic signed [SMP_W-1:0]	o_smp_left,
	input wire logic signed [SMP_W-1:0]	o_smp_right,
	input wire logic			o_vol_settled
);
	import advm_pkg::*;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rstn);
	// fine register write followed by a quiet cycle
	sequence s_fine_wr(b);
		i_reg_wr && i_reg_addr == 8'h52 && b ##1 !i_reg_wr;
	endsequence
	property p_rd_ans; i_reg_rd |=> o_reg_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_rsv; i_reg_rd && i_reg_addr inside {8'h53, 8'h54} |=> !o_reg_rdata[7]; endproperty
	a_rsv: assert property (p_rsv) else $error("coarse top bit set");
	property p_rdbk; s_fine_wr(1'b1) ##1 i_reg_rd && i_reg_addr == 8'h52 && !i_reg_wr
		|=> o_reg_rdata == $past(i_reg_wdata, 3); endproperty
	a_rdbk: assert property (p_rdbk) else $error("fine readback wrong");
	property p_mute_l; s_fine_wr(i_reg_wdata[7]) ##1 i_smp_valid && !i_reg_wr
		|=> o_smp_left == '0; endproperty
	a_mute_l: assert property (p_mute_l) else $error("left not muted");
	property p_mute_r; s_fine_wr(i_reg_wdata[3]) ##1 i_smp_valid && !i_reg_wr
		|=> o_smp_right == '0; endproperty
	a_mute_r: assert property (p_mute_r) else $error("right not muted");
	property p_smp_ans; i_smp_valid |=> o_smp_valid; endproperty
	a_smp_ans: assert property (p_smp_ans) else $error("sample not answered");
	property p_hold; !i_smp_valid |=> $stable(o_smp_left) && $stable(o_smp_right); endproperty
	a_hold: assert property (p_hold) else $error("sample moved");
	property p_settle; i_reg_wr && i_reg_addr == 8'h53 && i_step_rate[1]
		|-> ##[1:3] o_vol_settled; endproperty
	a_settle: assert property (p_settle) else $error("no immediate change");
endmodule : advm_volume_asserts

bind advm_volume advm_volume_asserts #(.SMP_W(SMP_W)) u_asserts (.i_ref_clk(i_ref_clk),
	.i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
	.i_step_rate(i_step_rate), .i_smp_valid(i_smp_valid), .o_smp_valid(o_smp_valid),
	.o_smp_left(o_smp_left), .o_smp_right(o_smp_right), .o_vol_settled(o_vol_settled));

//--- verification/tb_adc_digital_volume_mute.sv
// self-checking bench for the volume and mute stage
`timescale 1ns/1ps
module tb_adc_digital_volume_mute;
	import advm_pkg::*;
	logic			clk = 1'b0;
	logic			rstn = 1'b0;
	logic			wr = 1'b0;
	logic			rd = 1'b0;
	logic			sv = 1'b0;
	logic [7:0]		addr = 8'h00;
	logic [7:0]		wd = 8'h00;
	logic signed [15:0]	sl = 16'h0000;
	logic signed [15:0]	sr = 16'h0000;
	advm_rate_e		rate = ADVM_RATE_NOW;
	logic [7:0]		rdata;
	logic			rvalid;
	logic			ov;
	logic			settled;
	logic signed [15:0]	ol;
	logic signed [15:0]	orr;
	int			n_fail = 0;
	int			checks_done = 0;
	int			cnt;
	real			ft[5] = '{1.0, 0.98855, 0.97724, 0.96605, 0.95499};
	logic [7:0]		cd[7] = '{8'h18, 8'h68, 8'h40, 8'h7f, 8'h28, 8'h27, 8'h0c};
	// clock toggles every half period
	always #5 clk = ~clk;
	advm_volume #(.SMP_W(16)) u_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata),
		.o_reg_rvalid(rvalid), .i_step_rate(rate), .i_smp_valid(sv), .i_smp_left(sl),
		.i_smp_right(sr), .o_smp_valid(ov), .o_smp_left(ol), .o_smp_right(orr),
		.o_vol_settled(settled));
	//--------
	// tasks
	//--------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run();
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(16'(rvalid), 16'h0001);
		chk(16'(rdata), 16'(exp));
	endtask : rreg
	task automatic smp(input int l, input int r);
		@(posedge clk);
		sv <= 1'b1;
		sl <= 16'(l);
		sr <= 16'(r);
		@(posedge clk);
		sv <= 1'b0;
		#1;
		chk(16'(ov), 16'h0001);
	endtask : smp
	// model gain: coarse half-dB code clamped, six dB per octave, times fine factor
	function automatic real gain(input int c, input int f);
		int v;
		int oct;
		v = (c > 63) ? c - 128 : c;
		v = (v < -24) ? -24 : (v > 40) ? 40 : v;
		oct = (v + 48) / 12 - 4;
		return (2.0 ** oct) * (10.0 ** ((v - 12 * oct) / 40.0)) * ft[f];
	endfunction : gain
	task automatic gchk(input int cl, input int cr, input int fl, input int fr);
		int l;
		int r;
		logic signed [31:0] dl;
		logic signed [31:0] dr;
		l = int'($urandom_range(6000)) - 3000;
		r = int'($urandom_range(6000)) - 3000;
		smp(l, r);
		dl = ol - int'($floor(l * gain(cl, fl)));
		dr = orr - int'($floor(r * gain(cr, fr)));
		chk(16'(dl >= -3 && dl <= 3), 16'h0001);
		chk(16'(dr >= -3 && dr <= 3), 16'h0001);
	endtask : gchk
	task automatic steps();
		cnt = 0;
		#1;
		while (settled !== 1'b1 && cnt < 100)
		begin
			smp(100, 100);
			cnt++;
		end
		if (settled !== 1'b1)
		begin
			chk(16'(settled), 16'h0001);
			complete_run();
		end
	endtask : steps
	//--------
	// main sequence
	//--------
	initial
	begin
		cnt = $urandom(32'h8116_fe54);
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rreg(8'h52, 8'h88);
		rreg(8'h53, 8'h00);
		rreg(8'h54, 8'h00);
		rreg(8'h55, 8'h00);
		smp(1000, -1000);
		chk(16'(ol), 16'h0000);
		chk(16'(orr), 16'h0000);
		wreg(8'h52, 8'h80);
		smp(1000, -1000);
		chk(16'(ol), 16'h0000);
		chk(16'(orr), 16'hfc18);
		wreg(8'h52, 8'h08);
		smp(1000, -1000);
		chk(16'(ol), 16'h03e8);
		chk(16'(orr), 16'h0000);
		for (int f = 0; f < 5; f++)
		begin
			wreg(8'h52, 8'(f * 16 + 4 - f));
			rreg(8'h52, 8'(f * 16 + 4 - f));
			gchk(0, 0, f, 4 - f);
		end
		wreg(8'h52, 8'h20);
		for (int i = 0; i < 7; i++)
		begin
			wreg(8'h53, cd[i]);
			wreg(8'h54, cd[(i + 1) % 7]);
			rreg(8'h53, cd[i]);
			gchk(int'(cd[i]), int'(cd[(i + 1) % 7]), 2, 0);
		end
		wreg(8'h54, 8'h7f);
		rreg(8'h54, 8'h7f);
		wreg(8'h53, 8'h00);
		wreg(8'h54, 8'h00);
		rate <= ADVM_RATE_EACH;
		wreg(8'h53, 8'h18);
		steps();
		chk(16'(cnt), 16'h0018);
		rate <= ADVM_RATE_EVERY2;
		wreg(8'h53, 8'h00);
		steps();
		chk(16'(cnt == 47 || cnt == 48), 16'h0001);
		complete_run();
	end
endmodule : tb_adc_digital_volume_mute
